// ---- inc/bsts_regs.vh ----
// Purpose: constants of the boot self-test sequencer
// Assumes: 32-bit register port, word index addressing
// Notes: offsets are word indices; byte address is four times the index
`ifndef BSTS_REGS_VH
`define BSTS_REGS_VH
`define BSTS_NPART 8
`define BSTS_ADDR_W 6
// register indices
`define BSTS_A_CTRL 6'h00
`define BSTS_A_CFG 6'h01
`define BSTS_A_ERR 6'h02
`define BSTS_A_IRQ_ST 6'h03
`define BSTS_A_IRQ_MSK 6'h04
`define BSTS_A_STATE 6'h05
`define BSTS_A_OFF_LF 6'h08
`define BSTS_A_OFF_LU 6'h09
`define BSTS_A_OFF_MFL 6'h0a
`define BSTS_A_OFF_MFM 6'h0b
`define BSTS_A_OFF_MFH 6'h0c
`define BSTS_A_OFF_MUL 6'h0d
`define BSTS_A_OFF_MUM 6'h0e
`define BSTS_A_OFF_MUH 6'h0f
`define BSTS_A_ON_LF 6'h10
`define BSTS_A_ON_LU 6'h11
`define BSTS_A_ON_MFL 6'h12
`define BSTS_A_ON_MFM 6'h13
`define BSTS_A_ON_MFH 6'h14
`define BSTS_A_ON_MUL 6'h15
`define BSTS_A_ON_MUM 6'h16
`define BSTS_A_ON_MUH 6'h17
// ctrl bit: software start of an online run
`define BSTS_CTRL_GO 0
// cfg (test nvm) field positions
`define BSTS_CFG_LEN 0
`define BSTS_CFG_MEN 1
`define BSTS_CFG_SWOK 2
`define BSTS_CFG_FLT_FCU 3
// internal error bits
`define BSTS_ERR_TMO 0
`define BSTS_ERR_UNEXP 1
// irq bits
`define BSTS_IRQ_DONE 0
`define BSTS_IRQ_FAIL 1
`define BSTS_IRQ_CORR 2
`define BSTS_IRQ_IERR 3
`define BSTS_IRQ_W 4
// watchdog on a whole run, logic and memory tests counted together, in cycles
`define BSTS_TMO_CYC 20'h1_0000
`define BSTS_ZERO32 32'h0000_0000
`endif

// ---- rtl/bsts_seq.v ----
// Purpose: boot and online sequencing of logic and memory self-tests
// Assumes: engines run their partitions on a start pulse, report at done
// Notes: reset generation and fault collection are outside this block
`include "bsts_regs.vh"

module bsts_seq (
  input wire core_clk_in,
  input wire nrst_in,
  input wire por_in,
  input wire ext_rst_in,
  input wire destr_rst_in,
  input wire [31:0] nvm_cfg_in,
  input wire [`BSTS_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  output reg logic_self_test_start_out,
  input wire logic_self_test_done_in,
  input wire [`BSTS_NPART-1:0] logic_self_test_fail_in,
  input wire [`BSTS_NPART-1:0] logic_self_test_fin_in,
  output reg memory_self_test_start_out,
  input wire memory_self_test_done_in,
  input wire [3*`BSTS_NPART-1:0] memory_self_test_uncorr_in,
  input wire [3*`BSTS_NPART-1:0] memory_self_test_corr_in,
  input wire [3*`BSTS_NPART-1:0] memory_self_test_fin_in,
  output reg hold_reset_out,
  output reg cpu_release_out,
  output reg safe_state_out,
  output reg chip_reset_out,
  output reg fault_rgu_out,
  output reg fault_fcu_out,
  output wire irq_out
);

  // ******************************
  // states
  // ******************************
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_LRUN = 6'b000010;
  localparam [5:0] ST_MRUN = 6'b000100;
  localparam [5:0] ST_EVAL = 6'b001000;
  localparam [5:0] ST_RST = 6'b010000;
  localparam [5:0] ST_SAFE = 6'b100000;
  localparam NP = `BSTS_NPART;

  reg [5:0] st_q;
  reg online_q;
  reg lfail_q;
  reg mfail_q;
  reg booted_q;
  reg [19:0] tmo_q;
  reg [2:0] rq_s1, rq_s2, rq_s3;
  reg [NP-1:0] off_lf_q, off_lu_q, on_lf_q, on_lu_q;
  reg [3*NP-1:0] off_mf_q, off_mu_q, on_mf_q, on_mu_q;
  reg [1:0] err_q;
  reg [`BSTS_IRQ_W-1:0] ist_q, imsk_q;
  reg go_q;
  wire [`BSTS_IRQ_W-1:0] iev;
  wire boot_rq;
  wire len = nvm_cfg_in[`BSTS_CFG_LEN];
  wire men = nvm_cfg_in[`BSTS_CFG_MEN];
  wire tmo = (tmo_q == `BSTS_TMO_CYC);

  // reset sources are pins: three stages, act once stages two and three agree
  assign boot_rq = |(rq_s2 & rq_s3);

  // ******************************
  // sequencer
  // ******************************
  always @(posedge core_clk_in) begin
    rq_s1 <= {por_in, ext_rst_in, destr_rst_in};
    rq_s2 <= rq_s1;
    rq_s3 <= rq_s2;
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      online_q <= 1'b0;
      lfail_q <= 1'b0;
      mfail_q <= 1'b0;
      booted_q <= 1'b0;
      tmo_q <= 20'h0_0000;
      err_q <= 2'h0;
      logic_self_test_start_out <= 1'b0;
      memory_self_test_start_out <= 1'b0;
      hold_reset_out <= 1'b1;
      cpu_release_out <= 1'b0;
      safe_state_out <= 1'b0;
      chip_reset_out <= 1'b0;
      fault_rgu_out <= 1'b0;
      fault_fcu_out <= 1'b0;
      off_lf_q <= {NP{1'b0}};
      off_lu_q <= {NP{1'b0}};
      on_lf_q <= {NP{1'b0}};
      on_lu_q <= {NP{1'b0}};
      off_mf_q <= {3*NP{1'b0}};
      off_mu_q <= {3*NP{1'b0}};
      on_mf_q <= {3*NP{1'b0}};
      on_mu_q <= {3*NP{1'b0}};
    end else begin
      // a reset cause seen away from idle reruns the boot tests next idle
      if (boot_rq)
        booted_q <= 1'b0;
      logic_self_test_start_out <= 1'b0;
      memory_self_test_start_out <= 1'b0;
      chip_reset_out <= 1'b0;
      fault_rgu_out <= 1'b0;
      fault_fcu_out <= 1'b0;
      tmo_q <= (st_q == ST_LRUN || st_q == ST_MRUN) ?
               tmo_q + 20'h0_0001 : 20'h0_0000;
      case (st_q)
        ST_IDLE: begin
          if (boot_rq || !booted_q) begin
            // boot run, device held in reset
            booted_q <= 1'b1;
            online_q <= 1'b0;
            lfail_q <= 1'b0;
            mfail_q <= 1'b0;
            hold_reset_out <= 1'b1;
            cpu_release_out <= 1'b0;
            if (len) begin
              logic_self_test_start_out <= 1'b1;
              st_q <= ST_LRUN;
            end else if (men) begin
              memory_self_test_start_out <= 1'b1;
              st_q <= ST_MRUN;
            end else begin
              st_q <= ST_EVAL;
            end
          end else if (go_q && nvm_cfg_in[`BSTS_CFG_SWOK]
                       && (len || men)) begin
            // online run only when the configuration allows it
            online_q <= 1'b1;
            lfail_q <= 1'b0;
            mfail_q <= 1'b0;
            cpu_release_out <= 1'b0;
            logic_self_test_start_out <= len;
            memory_self_test_start_out <= !len;
            st_q <= len ? ST_LRUN : ST_MRUN;
          end
        end
        ST_LRUN: begin
          if (logic_self_test_done_in || tmo) begin
            if (online_q) begin
              on_lf_q <= logic_self_test_fail_in;
              on_lu_q <= ~logic_self_test_fin_in;
            end else begin
              off_lf_q <= logic_self_test_fail_in;
              off_lu_q <= ~logic_self_test_fin_in;
            end
            lfail_q <= (|logic_self_test_fail_in) | ~(&logic_self_test_fin_in) | tmo;
            if (tmo)
              err_q[`BSTS_ERR_TMO] <= 1'b1;
            if (men) begin
              memory_self_test_start_out <= 1'b1;
              st_q <= ST_MRUN;
            end else begin
              st_q <= ST_EVAL;
            end
          end
        end
        ST_MRUN: begin
          if (memory_self_test_done_in || tmo) begin
            // correctable hits are flagged, but only uncorrectable fail
            if (online_q) begin
              on_mf_q <= memory_self_test_uncorr_in | memory_self_test_corr_in;
              on_mu_q <= ~memory_self_test_fin_in;
            end else begin
              off_mf_q <= memory_self_test_uncorr_in | memory_self_test_corr_in;
              off_mu_q <= ~memory_self_test_fin_in;
            end
            mfail_q <= (|memory_self_test_uncorr_in) | ~(&memory_self_test_fin_in) | tmo;
            if (tmo)
              err_q[`BSTS_ERR_TMO] <= 1'b1;
            st_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (lfail_q || mfail_q || err_q != 2'h0) begin
            // fault path chosen by the nvm configuration
            fault_fcu_out <= nvm_cfg_in[`BSTS_CFG_FLT_FCU];
            fault_rgu_out <= !nvm_cfg_in[`BSTS_CFG_FLT_FCU];
          end
          if (lfail_q || mfail_q) begin
            safe_state_out <= 1'b1;
            st_q <= ST_SAFE;
          end else if (len || men || online_q) begin
            chip_reset_out <= 1'b1;
            st_q <= ST_RST;
          end else begin
            hold_reset_out <= 1'b0;
            cpu_release_out <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_RST: begin
          // flags survive this reset; only the next run of the same kind, boot or online, rewrites them
          hold_reset_out <= 1'b0;
          cpu_release_out <= 1'b1;
          online_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        ST_SAFE: begin
          // held until a fresh power-on, external or destructive reset
          hold_reset_out <= 1'b1;
          cpu_release_out <= 1'b0;
          if (boot_rq) begin
            safe_state_out <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          err_q[`BSTS_ERR_UNEXP] <= 1'b1;
          st_q <= ST_SAFE;
        end
      endcase
    end
  end

  // ******************************
  // register port
  // ******************************
  assign iev[`BSTS_IRQ_DONE] = chip_reset_out;
  assign iev[`BSTS_IRQ_FAIL] = st_q == ST_EVAL && (lfail_q || mfail_q);
  assign iev[`BSTS_IRQ_CORR] = st_q == ST_MRUN && memory_self_test_done_in
                               && (|memory_self_test_corr_in);
  assign iev[`BSTS_IRQ_IERR] = (st_q == ST_LRUN || st_q == ST_MRUN) && tmo;
  assign irq_out = |(ist_q & imsk_q);

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      go_q <= 1'b0;
      ist_q <= {`BSTS_IRQ_W{1'b0}};
      imsk_q <= {`BSTS_IRQ_W{1'b0}};
    end else begin
      // request is held until the sequencer is idle after boot, then dropped whether taken or not
      if (wr_in && addr_in == `BSTS_A_CTRL)
        go_q <= wdata_in[`BSTS_CTRL_GO];
      else if (st_q == ST_IDLE && booted_q)
        go_q <= 1'b0;
      if (wr_in && addr_in == `BSTS_A_IRQ_MSK)
        imsk_q <= wdata_in[`BSTS_IRQ_W-1:0];
      // set wins over a write-one clear in the same cycle
      if (wr_in && addr_in == `BSTS_A_IRQ_ST)
        ist_q <= (ist_q & ~wdata_in[`BSTS_IRQ_W-1:0]) | iev;
      else
        ist_q <= ist_q | iev;
    end
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in)
      rdata_out <= `BSTS_ZERO32;
    else if (!rd_in)
      rdata_out <= `BSTS_ZERO32;
    else if (addr_in == `BSTS_A_CTRL)
      rdata_out <= {31'h0000_0000, go_q};
    else if (addr_in == `BSTS_A_CFG)
      rdata_out <= nvm_cfg_in;
    else if (addr_in == `BSTS_A_ERR)
      rdata_out <= {30'h0000_0000, err_q};
    else if (addr_in == `BSTS_A_IRQ_ST)
      rdata_out <= {28'h000_0000, ist_q};
    else if (addr_in == `BSTS_A_IRQ_MSK)
      rdata_out <= {28'h000_0000, imsk_q};
    else if (addr_in == `BSTS_A_STATE)
      rdata_out <= {26'h000_0000, st_q};
    else if (addr_in == `BSTS_A_OFF_LF)
      rdata_out <= {24'h00_0000, off_lf_q};
    else if (addr_in == `BSTS_A_OFF_LU)
      rdata_out <= {24'h00_0000, off_lu_q};
    else if (addr_in == `BSTS_A_OFF_MFL)
      rdata_out <= {24'h00_0000, off_mf_q[NP-1:0]};
    else if (addr_in == `BSTS_A_OFF_MFM)
      rdata_out <= {24'h00_0000, off_mf_q[2*NP-1:NP]};
    else if (addr_in == `BSTS_A_OFF_MFH)
      rdata_out <= {24'h00_0000, off_mf_q[3*NP-1:2*NP]};
    else if (addr_in == `BSTS_A_OFF_MUL)
      rdata_out <= {24'h00_0000, off_mu_q[NP-1:0]};
    else if (addr_in == `BSTS_A_OFF_MUM)
      rdata_out <= {24'h00_0000, off_mu_q[2*NP-1:NP]};
    else if (addr_in == `BSTS_A_OFF_MUH)
      rdata_out <= {24'h00_0000, off_mu_q[3*NP-1:2*NP]};
    else if (addr_in == `BSTS_A_ON_LF)
      rdata_out <= {24'h00_0000, on_lf_q};
    else if (addr_in == `BSTS_A_ON_LU)
      rdata_out <= {24'h00_0000, on_lu_q};
    else if (addr_in == `BSTS_A_ON_MFL)
      rdata_out <= {24'h00_0000, on_mf_q[NP-1:0]};
    else if (addr_in == `BSTS_A_ON_MFM)
      rdata_out <= {24'h00_0000, on_mf_q[2*NP-1:NP]};
    else if (addr_in == `BSTS_A_ON_MFH)
      rdata_out <= {24'h00_0000, on_mf_q[3*NP-1:2*NP]};
    else if (addr_in == `BSTS_A_ON_MUL)
      rdata_out <= {24'h00_0000, on_mu_q[NP-1:0]};
    else if (addr_in == `BSTS_A_ON_MUM)
      rdata_out <= {24'h00_0000, on_mu_q[2*NP-1:NP]};
    else if (addr_in == `BSTS_A_ON_MUH)
      rdata_out <= {24'h00_0000, on_mu_q[3*NP-1:2*NP]};
    else
      rdata_out <= `BSTS_ZERO32;
  end

endmodule // bsts_seq

// ---- verif/bsts_seq_properties.sv ----
// Purpose: port-level checks of the self-test sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: cycle offsets follow the hand-over timing of a run
`include "bsts_regs.vh"
module bsts_seq_props (
  input logic core_clk_in,
  input logic nrst_in,
  input logic por_in,
  input logic ext_rst_in,
  input logic destr_rst_in,
  input logic [31:0] nvm_cfg_in,
  input logic logic_self_test_start_out,
  input logic logic_self_test_done_in,
  input logic [`BSTS_NPART-1:0] logic_self_test_fail_in,
  input logic [`BSTS_NPART-1:0] logic_self_test_fin_in,
  input logic memory_self_test_start_out,
  input logic memory_self_test_done_in,
  input logic [3*`BSTS_NPART-1:0] memory_self_test_uncorr_in,
  input logic [3*`BSTS_NPART-1:0] memory_self_test_fin_in,
  input logic cpu_release_out,
  input logic safe_state_out,
  input logic chip_reset_out,
  input logic fault_rgu_out,
  input logic fault_fcu_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // helpers
  // ******
  logic lf_q;
  logic [7:0] pin_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // remembers a bad logic run so a pass reset after it is caught
  always @(posedge core_clk_in) begin
    pin_q <= {pin_q[6:0], por_in | ext_rst_in | destr_rst_in};
    if (!nrst_in || logic_self_test_start_out || safe_state_out) begin
      lf_q <= 1'b0;
    end else if (logic_self_test_done_in && (|logic_self_test_fail_in || !(&logic_self_test_fin_in))) begin
      lf_q <= 1'b1;
    end
  end
  sequence mem_ok_s;
    memory_self_test_done_in && !(|memory_self_test_uncorr_in) && (&memory_self_test_fin_in) && !lf_q;
  endsequence
  sequence end_s;
    ##2 (chip_reset_out || $rose(safe_state_out));
  endsequence
  boot_start_a: assert property (
    $rose(nrst_in) && nvm_cfg_in[0] |-> ##[1:4] logic_self_test_start_out)
    else $error("no boot start");
  mem_order_a: assert property (
    memory_self_test_start_out && nvm_cfg_in[0] |-> $past(logic_self_test_done_in))
    else $error("memory before logic");
  mem_reset_a: assert property (mem_ok_s |-> ##2 chip_reset_out)
    else $error("no reset after memory run");
  mem_fail_a: assert property (
    memory_self_test_done_in && |memory_self_test_uncorr_in |-> ##2 safe_state_out && !chip_reset_out)
    else $error("uncorrectable not blocked");
  logic_end_a: assert property (
    logic_self_test_done_in && !nvm_cfg_in[1] |-> end_s)
    else $error("no reset after logic run");
  logic_fail_a: assert property (chip_reset_out |-> !lf_q)
    else $error("pass after logic fail");
  fault_route_a: assert property (
    fault_fcu_out || fault_rgu_out |->
      fault_fcu_out == nvm_cfg_in[3] && fault_rgu_out != nvm_cfg_in[3])
    else $error("fault routed wrong");
  safe_fault_a: assert property (
    $rose(safe_state_out) |-> fault_fcu_out || fault_rgu_out)
    else $error("safe state without fault");
  safe_hold_a: assert property ($fell(safe_state_out) |-> |pin_q)
    else $error("safe state left");
  safe_block_a: assert property (safe_state_out |-> !cpu_release_out)
    else $error("released in safe state");
endmodule // bsts_seq_props

bind bsts_seq bsts_seq_props u_props (
  .core_clk_in, .nrst_in, .por_in, .ext_rst_in, .destr_rst_in,
  .nvm_cfg_in, .logic_self_test_start_out, .logic_self_test_done_in, .logic_self_test_fail_in,
  .logic_self_test_fin_in, .memory_self_test_start_out, .memory_self_test_done_in, .memory_self_test_uncorr_in,
  .memory_self_test_fin_in, .cpu_release_out, .safe_state_out, .chip_reset_out,
  .fault_rgu_out, .fault_fcu_out);

// ---- verif/bsts_eng_model.sv ----
// Purpose: self-test engine model answering a start pulse
// Assumes: result lines are valid only in the done cycle
// Notes: outside done the lines show the inverse to expose early sampling
module bsts_eng_model #(
  parameter W = 16
) (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [3:0] lat_in,
  input wire logic [W-1:0] res_in,
  output logic done_out,
  output logic [W-1:0] res_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  initial done_out = 1'b0;
  assign res_out = done_out ? res_in : ~res_in;
  always @(posedge clk_in) begin
    done_out <= busy_q && cnt_q == 4'h0;
    if (start_in) begin
      busy_q <= 1'b1;
      cnt_q <= lat_in;
    end else if (busy_q) begin
      busy_q <= cnt_q != 4'h0;
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // bsts_eng_model

// ---- verif/bsts_seq_tb.sv ----
// Purpose: self-checking bench of the self-test sequencer
// Assumes: engine models stand for the logic and memory test engines
// Notes: run outcomes and read data are queued by the driver
`include "bsts_regs.vh"
module bsts_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic por_in = 1'b0, ext_rst_in = 1'b0, destr_rst_in = 1'b0;
  logic [31:0] nvm_cfg_in = 32'hf, wdata_in = 32'h0, r;
  logic [5:0] addr_in = 6'h0;
  logic [3:0] lat = 4'h0;
  logic [15:0] lres = 16'hff00;
  logic [71:0] mres = {24'hff_ffff, 48'h0};
  logic [31:0] rdata_out;
  logic logic_self_test_start_out, logic_self_test_done_in, memory_self_test_start_out, memory_self_test_done_in;
  logic hold_reset_out, cpu_release_out, safe_state_out, chip_reset_out;
  logic fault_rgu_out, fault_fcu_out, irq_out, ss_q = 1'b0, rd_q = 1'b0;
  logic [7:0] logic_self_test_fail_in, logic_self_test_fin_in;
  logic [23:0] memory_self_test_uncorr_in, memory_self_test_corr_in, memory_self_test_fin_in;
  logic oq[$];
  logic [31:0] rq[$];
  int error_cnt = 0, total_checks = 0;
  bsts_seq uut (.core_clk_in, .nrst_in, .por_in, .ext_rst_in, .destr_rst_in,
    .nvm_cfg_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .logic_self_test_start_out, .logic_self_test_done_in, .logic_self_test_fail_in, .logic_self_test_fin_in,
    .memory_self_test_start_out, .memory_self_test_done_in, .memory_self_test_uncorr_in, .memory_self_test_corr_in,
    .memory_self_test_fin_in, .hold_reset_out, .cpu_release_out, .safe_state_out,
    .chip_reset_out, .fault_rgu_out, .fault_fcu_out, .irq_out);
  bsts_eng_model #(.W(16)) u_lgc (.clk_in(core_clk_in),
    .start_in(logic_self_test_start_out), .lat_in(lat), .res_in(lres),
    .done_out(logic_self_test_done_in), .res_out({logic_self_test_fin_in, logic_self_test_fail_in}));
  bsts_eng_model #(.W(72)) u_mem (.clk_in(core_clk_in),
    .start_in(memory_self_test_start_out), .lat_in(lat), .res_in(mres),
    .done_out(memory_self_test_done_in),
    .res_out({memory_self_test_fin_in, memory_self_test_corr_in, memory_self_test_uncorr_in}));
  // ******
  // tasks
  // ******
  task cmp_w(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task cmp_b(input logic e, input logic g);
    cmp_w({31'h0, e}, {31'h0, g});
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
  endtask
  // bounded so a lost outcome cannot hang the run
  task run_wait();
    int n;
    n = 0;
    while (oq.size() != 0 && n < 300) begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (3) @(posedge core_clk_in);
    #1 cmp_w(32'h0, oq.size());
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ******
  // watcher, clock, timeout, sequence
  // ******
  always @(posedge core_clk_in) begin
    if (chip_reset_out === 1'b1 || (safe_state_out === 1'b1 && ss_q !== 1)) begin
      if (oq.size() == 0) cmp_b(1'b0, 1'b1);
      else cmp_b(oq.pop_front(), chip_reset_out);
    end
    if (rd_q) cmp_w(rq.pop_front(), rdata_out);
    ss_q <= safe_state_out;
    rd_q <= rd_in;
  end
  initial forever #20 core_clk_in = ~core_clk_in;
  initial begin
    repeat (5000) @(posedge core_clk_in);
    error_cnt++;
    print_verdict();
  end
  initial begin
    void'($urandom(66));
    oq.push_back(1'b1);
    repeat (4) @(posedge core_clk_in);
    cmp_b(1'b1, hold_reset_out);
    nrst_in <= 1'b1;
    run_wait();
    cmp_b(1'b1, cpu_release_out);
    cmp_b(1'b0, hold_reset_out);
    rd(`BSTS_A_OFF_LU, 32'h0);
    rd(`BSTS_A_CFG, 32'hf);
    rd(`BSTS_A_ERR, 32'h0);
    rd(6'h3f, 32'h0);
    $display("boot test done");
    r = $urandom | 32'h1;
    mres[47:24] <= r[23:0];
    lat <= r[27:24];
    wr(`BSTS_A_IRQ_MSK, 32'h4);
    oq.push_back(1'b1);
    wr(`BSTS_A_CTRL, 32'h1);
    run_wait();
    cmp_b(1'b1, irq_out);
    rd(`BSTS_A_ON_MFL, {24'h0, r[7:0]});
    rd(`BSTS_A_ON_MFM, {24'h0, r[15:8]});
    rd(`BSTS_A_OFF_MFL, 32'h0);
    wr(`BSTS_A_IRQ_ST, 32'hf);
    #1 cmp_b(1'b0, irq_out);
    $display("online correctable test done");
    r = $urandom | 32'h1;
    mres <= {24'hff_ffff, 48'h0};
    nvm_cfg_in <= 32'hd;
    lres <= {8'hff, r[7:0]};
    lat <= r[11:8];
    oq.push_back(1'b0);
    wr(`BSTS_A_CTRL, 32'h1);
    run_wait();
    cmp_b(1'b0, cpu_release_out);
    cmp_b(1'b1, hold_reset_out);
    rd(`BSTS_A_IRQ_ST, 32'h2);
    rd(`BSTS_A_ON_LF, {24'h0, r[7:0]});
    rd(`BSTS_A_OFF_LF, 32'h0);
    $display("online logic fail test done");
    nvm_cfg_in <= 32'h3;
    for (int i = 0; i < 3; i++) begin
      lres <= (i == 0) ? 16'h7f00 : 16'hff00;
      mres <= {24'hff_ffff, 24'h0, (i == 1) ? 24'h1_0000 : 24'h0};
      oq.push_back(i == 2);
      {destr_rst_in, ext_rst_in, por_in} <= 3'h1 << i;
      repeat (2) @(posedge core_clk_in);
      {destr_rst_in, ext_rst_in, por_in} <= 3'h0;
      run_wait();
      if (i == 0) rd(`BSTS_A_OFF_LU, 32'h80);
      if (i == 1) rd(`BSTS_A_OFF_MFH, 32'h1);
    end
    rd(`BSTS_A_ON_LF, {24'h0, r[7:0]});
    rd(`BSTS_A_ERR, 32'h0);
    cmp_b(1'b1, cpu_release_out);
    $display("reset pin test done");
    repeat (2) @(posedge core_clk_in);
    print_verdict();
  end
endmodule // bsts_seq_tb
